// *** rvsc_top.sv ***
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// What this block does
// - Take an interrupt only with its own enable and the global enable set.
// - Fixed vectors: reset at 0, eight sources at word addresses 1 to 8.
// - Simultaneous requests resolve by address, lower address wins.
// - Power-on, pin, watchdog and brown-out resets share the reset vector.
// - Pin held low over 500 ns resets; shorter pulses may be ignored.
// - Watchdog expiry resets only while the watchdog is enabled.
// - Reset loads control registers with initial values; event status and mask are kept; fetch restarts at 0.
// - Working register contents are not touched by any reset.
// - Select 00 or 01 waits 64K oscillator cycles then 18 clocks.
// - Select 10 waits 4K oscillator cycles then 18 clocks.
// - Select 11 waits 8 cycles, or 32 with brown-out fuse programmed.
// - Wake from power-down runs only the 18 clock part.
// - Delay starts when power-on releases; reasserts reset at once.
// - Start-up select holds code 00 until the fuses are captured.
// - Watchdog gives a one-clock pulse; counting starts after it ends.
// - After the pin returns high the selected delay runs before release.
module rvsc_top #(
	parameter int OSC_LONG = rvsc_pkg::OSC_LONG_CYC // long oscillator count
) (
	input  wire logic        pclk,         // system clock, 40 MHz
	input  wire logic        presetn,      // async reset, active low
	input  wire logic        ce,           // clock enable, freezes state
	// apb slave
	input  wire logic        psel,         // select
	input  wire logic        penable,      // access phase
	input  wire logic        pwrite,       // write direction
	input  wire logic [7:0]  paddr,        // byte address
	input  wire logic [31:0] pwdata,       // write data
	output logic      [31:0] prdata,       // read data
	output logic             pready,       // transfer done
	output logic             pslverr,      // unmapped address
	// reset sources
	input  wire logic        por_active,   // power-on detector, high below threshold
	input  wire logic        ext_reset_n,  // reset pin, active low
	input  wire logic        wdt_expire,   // watchdog period expired
	input  wire logic        wdt_enable,   // watchdog enabled
	input  wire logic        bod_active,   // brown-out detector below threshold
	input  wire logic        osc_tick,     // one pulse per watchdog oscillator cycle
	input  wire logic        pd_wake,      // wake from power-down pulse
	// fuses
	input  wire logic [1:0]  startup_delay_select, // start-up select fuses
	input  wire logic        brownout_enable_fuse, // 0 = programmed
	input  wire logic        brownout_level_fuse,  // level select, reported only
	// interrupt sources and core
	input  wire logic [7:0]  irq_src,      // source flags, bit 0 = ext_irq_zero
	input  wire logic        core_irq_ack, // core takes the offered vector
	output logic             core_reset_n, // core and i/o reset, active low
	output logic             core_hold,    // core clock held during delay
	output logic [8:0]       core_vector,  // vector word address to fetch
	output logic             core_irq,     // interrupt offered to core
	output logic             irq           // event interrupt, level
);
	// ==========================================================
	// declarations
	rvsc_pkg::rvsc_state_t state_q;
	logic [16:0] osc_cnt_q;
	logic [4:0]  clk_cnt_q;
	logic [1:0]  sel_q;
	logic        bod_fuse_q;
	logic        fuse_taken_q;
	logic        wdt_pulse_q;
	logic        wdt_seen_q;
	logic        gie_q;
	logic [7:0]  irq_en_q;
	logic [4:0]  evt_q;
	logic [4:0]  evt_mask_q;
	logic        ext_active;
	logic        bod_reset;
	logic        any_reset;
	logic        wr_en;
	logic        rd_setup;
	logic        mapped;
	logic        release_ev;
	logic [16:0] osc_target;
	logic [4:0]  evt_set;
	logic [31:0] rd_word;

	rvsc_irq_if irq_bus ();

	// ==========================================================
	// helpers
	// oscillator count for a select code and brown-out fuse
	function automatic logic [16:0] osc_count(input logic [1:0] sel, input logic bod_f);
		logic [16:0] r;
		r = 17'(OSC_LONG);
		if (sel == rvsc_pkg::SEL_MID) begin
			r = rvsc_pkg::OSC_MID_CYC;
		end else if (sel == rvsc_pkg::SEL_SHORT) begin
			r = (bod_f == rvsc_pkg::FUSE_PROG) ? rvsc_pkg::OSC_BOD_CYC
			                                   : rvsc_pkg::OSC_SHORT_CYC;
		end
		return r;
	endfunction : osc_count

	// address hit test, used by read mux and error flag
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	// ==========================================================
	// reset source qualification
	rvsc_ext_filter u_ext (
		.pclk       (pclk),
		.presetn    (presetn),
		.ce         (ce),
		.pin_n      (ext_reset_n),
		.ext_active (ext_active)
	);

	// brown-out only acts when its enable fuse is programmed
	assign bod_reset = bod_active && (brownout_enable_fuse == rvsc_pkg::FUSE_PROG);
	// every source lands on the same hold path and so the same vector
	assign any_reset = por_active || ext_active || bod_reset || wdt_pulse_q;
	assign osc_target = osc_count(sel_q, bod_fuse_q);

	// ==========================================================
	// watchdog pulse, one clock wide per expiry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_pulse_q <= 1'b0;
			wdt_seen_q  <= 1'b0;
		end else if (ce) begin
			wdt_seen_q  <= wdt_expire;
			// edge of expiry, gated by enable; a disabled watchdog never resets
			wdt_pulse_q <= wdt_expire && !wdt_seen_q && wdt_enable;
		end
	end

	// ==========================================================
	// fuse capture after reset release; select reads 00 until then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q        <= rvsc_pkg::SEL_RESET;
			bod_fuse_q   <= 1'b1;
			fuse_taken_q <= 1'b0;
		end else if (ce && !fuse_taken_q) begin
			sel_q        <= startup_delay_select;
			bod_fuse_q   <= brownout_enable_fuse;
			fuse_taken_q <= 1'b1;
		end
	end

	// ==========================================================
	// start-up delay sequencer
	// a source that returns mid-count throws the count away, so the
	// core only ever sees one full uninterrupted delay
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q   <= rvsc_pkg::ST_HOLD;
			osc_cnt_q <= 17'h00000;
			clk_cnt_q <= 5'h00;
		end else if (ce) begin
			if (any_reset || !fuse_taken_q) begin
				state_q   <= rvsc_pkg::ST_HOLD;
				osc_cnt_q <= 17'h00000;
				clk_cnt_q <= 5'h00;
			end else begin
				unique case (state_q)
					rvsc_pkg::ST_HOLD: begin
						state_q <= rvsc_pkg::ST_OSC;
					end
					rvsc_pkg::ST_OSC: begin
						if (osc_cnt_q == osc_target) begin
							state_q <= rvsc_pkg::ST_CLK;
						end else if (osc_tick) begin
							osc_cnt_q <= osc_cnt_q + 17'h00001;
						end
					end
					rvsc_pkg::ST_CLK: begin
						if (clk_cnt_q == rvsc_pkg::SYS_CLK_CYC - 5'h01) begin
							state_q <= rvsc_pkg::ST_RUN;
						end else begin
							clk_cnt_q <= clk_cnt_q + 5'h01;
						end
					end
					rvsc_pkg::ST_RUN: begin
						if (pd_wake) begin
							// wake skips oscillator counting altogether
							state_q   <= rvsc_pkg::ST_CLK;
							clk_cnt_q <= 5'h00;
						end
					end
				endcase
			end
		end
	end

	assign release_ev = ce && (state_q == rvsc_pkg::ST_CLK) && !any_reset && fuse_taken_q
	                    && (clk_cnt_q == rvsc_pkg::SYS_CLK_CYC - 5'h01);

	// ==========================================================
	// core controls
	// only a true reset drops core_reset_n; the working register file sits
	// in the core and is never on this path, so its contents survive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_reset_n <= 1'b0;
			core_hold    <= 1'b1;
			core_vector  <= rvsc_pkg::VEC_RESET;
			core_irq     <= 1'b0;
		end else if (ce) begin
			if (any_reset || !fuse_taken_q) begin
				core_reset_n <= 1'b0;
			end else if (release_ev && !core_reset_n) begin
				core_reset_n <= 1'b1;
			end
			core_hold <= !(release_ev || (state_q == rvsc_pkg::ST_RUN && !pd_wake));
			if (!core_reset_n || any_reset) begin
				core_vector <= rvsc_pkg::VEC_RESET;
				core_irq    <= 1'b0;
			end else begin
				core_irq <= irq_bus.valid && !core_irq_ack && (state_q == rvsc_pkg::ST_RUN);
				if (irq_bus.valid) begin
					core_vector <= {5'h00, irq_bus.vec};
				end
			end
		end
	end

	// ==========================================================
	// interrupt gating: a source needs its own enable and the global one
	assign irq_bus.req = irq_src & irq_en_q & {rvsc_pkg::NUM_IRQ{gie_q}};

	rvsc_prio_enc u_enc (
		.irq (irq_bus)
	);

	// ==========================================================
	// apb decode; zero-wait answer one cycle after setup
	assign wr_en    = psel && penable && pready && pwrite;
	assign rd_setup = psel && !penable;
	assign mapped   = hit(paddr, rvsc_pkg::OFS_CTRL) || hit(paddr, rvsc_pkg::OFS_IRQ_EN)
	               || hit(paddr, rvsc_pkg::OFS_EVT_STAT) || hit(paddr, rvsc_pkg::OFS_EVT_MASK)
	               || hit(paddr, rvsc_pkg::OFS_STATE);

	// read mux, live state is sampled in the setup cycle
	always_comb begin
		rd_word = 32'h00000000;
		if (hit(paddr, rvsc_pkg::OFS_CTRL)) begin
			rd_word[rvsc_pkg::CTRL_GIE_BIT] = gie_q;
		end else if (hit(paddr, rvsc_pkg::OFS_IRQ_EN)) begin
			rd_word[7:0] = irq_en_q;
		end else if (hit(paddr, rvsc_pkg::OFS_EVT_STAT)) begin
			rd_word[4:0] = evt_q;
		end else if (hit(paddr, rvsc_pkg::OFS_EVT_MASK)) begin
			rd_word[4:0] = evt_mask_q;
		end else if (hit(paddr, rvsc_pkg::OFS_STATE)) begin
			rd_word[1:0]   = state_q;
			rd_word[3:2]   = sel_q;
			rd_word[4]     = bod_fuse_q;
			rd_word[5]     = brownout_level_fuse;
			rd_word[6]     = core_reset_n;
			rd_word[16:8]  = core_vector;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (ce) begin
			pready  <= rd_setup;
			pslverr <= rd_setup && !mapped;
			if (rd_setup && !pwrite) begin
				prdata <= rd_word;
			end
		end
	end

	// ==========================================================
	// control registers, reloaded to initial values on core reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gie_q    <= rvsc_pkg::GIE_RESET;
			irq_en_q <= rvsc_pkg::IRQ_EN_RESET;
		end else if (ce) begin
			if (!core_reset_n) begin
				gie_q    <= rvsc_pkg::GIE_RESET;
				irq_en_q <= rvsc_pkg::IRQ_EN_RESET;
			end else begin
				if (wr_en && hit(paddr, rvsc_pkg::OFS_CTRL)) begin
					gie_q <= pwdata[rvsc_pkg::CTRL_GIE_BIT];
				end else if (core_irq && core_irq_ack) begin
					gie_q <= 1'b0; // taken interrupt masks further ones
				end
				if (wr_en && hit(paddr, rvsc_pkg::OFS_IRQ_EN)) begin
					irq_en_q <= pwdata[7:0];
				end
			end
		end
	end

	// ==========================================================
	// event status, write one to clear, a new event beats the clear
	assign evt_set[rvsc_pkg::EVT_POR_BIT] = por_active;
	assign evt_set[rvsc_pkg::EVT_EXT_BIT] = ext_active;
	assign evt_set[rvsc_pkg::EVT_WDT_BIT] = wdt_pulse_q;
	assign evt_set[rvsc_pkg::EVT_BOD_BIT] = bod_reset;
	assign evt_set[rvsc_pkg::EVT_REL_BIT] = release_ev;

	// status survives reset of the core so software can find the cause
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evt_q      <= rvsc_pkg::EVT_RESET;
			evt_mask_q <= rvsc_pkg::EVT_RESET;
			irq        <= 1'b0;
		end else if (ce) begin
			if (wr_en && hit(paddr, rvsc_pkg::OFS_EVT_STAT)) begin
				evt_q <= (evt_q & ~pwdata[4:0]) | evt_set;
			end else begin
				evt_q <= evt_q | evt_set;
			end
			if (wr_en && hit(paddr, rvsc_pkg::OFS_EVT_MASK)) begin
				evt_mask_q <= pwdata[4:0];
			end
			irq <= |(evt_q & evt_mask_q);
		end
	end

endmodule : rvsc_top

// *** rvsc_pkg.sv ***
// ==========================================================
// reset / vector startup control constants
package rvsc_pkg;

	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_IRQ_EN   = 8'h04;
	localparam logic [7:0] OFS_EVT_STAT = 8'h08;
	localparam logic [7:0] OFS_EVT_MASK = 8'h0C;
	localparam logic [7:0] OFS_STATE    = 8'h10;

	// ==========================================================
	// field positions
	localparam int CTRL_GIE_BIT  = 0;
	localparam int EVT_POR_BIT   = 0;
	localparam int EVT_EXT_BIT   = 1;
	localparam int EVT_WDT_BIT   = 2;
	localparam int EVT_BOD_BIT   = 3;
	localparam int EVT_REL_BIT   = 4;
	localparam int EVT_W         = 5;
	localparam int NUM_IRQ       = 8;

	// ==========================================================
	// reset values
	localparam logic [1:0]  SEL_RESET     = 2'h0;
	localparam logic        GIE_RESET     = 1'b0;
	localparam logic [7:0]  IRQ_EN_RESET  = 8'h00;
	localparam logic [4:0]  EVT_RESET     = 5'h00;
	localparam logic        FUSE_PROG     = 1'b0;

	// ==========================================================
	// vector word addresses
	localparam logic [8:0] VEC_RESET     = 9'h000;
	localparam logic [8:0] VEC_FIRST_IRQ = 9'h001;
	localparam logic [8:0] VEC_LAST_IRQ  = 9'h008;

	// ==========================================================
	// start-up select codes
	localparam logic [1:0] SEL_LONG_A = 2'h0;
	localparam logic [1:0] SEL_LONG_B = 2'h1;
	localparam logic [1:0] SEL_MID    = 2'h2;
	localparam logic [1:0] SEL_SHORT  = 2'h3;

	// ==========================================================
	// timing counts
	localparam int CLK_PERIOD_NS  = 25;
	localparam int EXT_MIN_NS     = 500;
	localparam int EXT_MIN_CYC    = (EXT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OSC_LONG_CYC   = 65536;
	localparam logic [16:0] OSC_MID_CYC   = 17'h01000;
	localparam logic [16:0] OSC_SHORT_CYC = 17'h00008;
	localparam logic [16:0] OSC_BOD_CYC   = 17'h00020;
	localparam logic [4:0]  SYS_CLK_CYC   = 5'h12;

	// delay sequencer states, gray along hold -> osc -> clk -> run
	typedef enum logic [1:0] {
		ST_HOLD = 2'b00,
		ST_OSC  = 2'b01,
		ST_CLK  = 2'b11,
		ST_RUN  = 2'b10
	} rvsc_state_t;

endpackage : rvsc_pkg

// *** rvsc_irq_if.sv ***
`timescale 1ns/1ps
// ==========================================================
// request bundle between the top and the priority encoder
interface rvsc_irq_if;
	logic [7:0] req;  // pending and enabled sources
	logic       valid; // any request present
	logic [3:0] vec;  // winning vector word address
	modport enc (input req, output valid, output vec);
	modport top (output req, input valid, input vec);
endinterface : rvsc_irq_if

// *** rvsc_prio_enc.sv ***
`timescale 1ns/1ps
// ==========================================================
// fixed priority encoder, lowest source index wins
module rvsc_prio_enc (
	rvsc_irq_if.enc irq // request bundle
);
	// scan from highest index down so the lowest set bit is kept last
	always_comb begin
		irq.valid = 1'b0;
		irq.vec   = 4'h0;
		for (int i = rvsc_pkg::NUM_IRQ - 1; i >= 0; i--) begin
			if (irq.req[i]) begin
				irq.valid = 1'b1;
				irq.vec   = 4'(rvsc_pkg::VEC_FIRST_IRQ + 9'(i));
			end
		end
	end
endmodule : rvsc_prio_enc

// *** rvsc_ext_filter.sv ***
`timescale 1ns/1ps
// ==========================================================
// reset pin low-time qualifier
module rvsc_ext_filter (
	input  wire logic pclk,        // system clock
	input  wire logic presetn,     // async reset, active low
	input  wire logic ce,          // clock enable
	input  wire logic pin_n,       // reset pin level, active low
	output logic      ext_active   // qualified external reset level
);
	localparam logic [4:0] LIMIT = 5'(rvsc_pkg::EXT_MIN_CYC);

	logic [4:0] low_cnt_q;

	// only a low lasting the full minimum counts; short glitches are dropped
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_cnt_q  <= 5'h00;
			ext_active <= 1'b0;
		end else if (ce) begin
			if (pin_n) begin
				low_cnt_q  <= 5'h00;
				ext_active <= 1'b0;
			end else if (low_cnt_q != LIMIT) begin
				low_cnt_q <= low_cnt_q + 5'h01;
			end else begin
				ext_active <= 1'b1;
			end
		end
	end
endmodule : rvsc_ext_filter

// *** rvsc_top_end.sv ***
`timescale 1ns/1ps

// *** rvsc_top_sva.sv ***
`timescale 1ns/1ps
// ==========================================================
// port-level checks of reset sequencing, vectors and apb
module rvsc_top_sva #(
	parameter int OSC_LONG = rvsc_pkg::OSC_LONG_CYC // long oscillator count
) (
	input wire logic       pclk,         // clock
	input wire logic       presetn,      // async reset
	input wire logic       psel,         // select
	input wire logic       penable,      // access phase
	input wire logic [7:0] paddr,        // byte address
	input wire logic       pready,       // done
	input wire logic       pslverr,      // error
	input wire logic       por_active,   // power-on detector
	input wire logic       ext_reset_n,  // reset pin
	input wire logic       wdt_expire,   // watchdog expiry
	input wire logic       wdt_enable,   // watchdog on
	input wire logic       bod_active,   // brown-out detector
	input wire logic       pd_wake,      // wake pulse
	input wire logic [7:0] irq_src,      // source flags
	input wire logic       core_reset_n, // core reset
	input wire logic       core_hold,    // core held
	input wire logic [8:0] core_vector,  // vector
	input wire logic       core_irq,     // offer
	input wire logic       core_irq_ack  // take
);
	logic [7:0]  low_q;   // consecutive pin-low cycles
	logic [15:0] quiet_q; // cycles since power-on, brown-out or pin low was last seen

	// both counters saturate so a long run never wraps back into range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_q <= 8'h00;
		end else begin
			low_q <= ext_reset_n ? 8'h00 : (low_q == 8'hFF ? low_q : low_q + 8'h01);
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_q <= 16'h0000;
		end else if (por_active || bod_active || !ext_reset_n) begin
			quiet_q <= 16'h0000;
		end else begin
			quiet_q <= (quiet_q == 16'hFFFF) ? quiet_q : quiet_q + 16'h0001;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================
	// reset sequencing
	property p_vec_in_reset;
		!core_reset_n && !$past(core_reset_n) |-> core_vector == 9'h000 && !core_irq;
	endproperty
	a_vec_in_reset: assert property (p_vec_in_reset) else $error("vector not zero");
	property p_por_now;
		por_active |=> !core_reset_n;
	endproperty
	a_por_now: assert property (p_por_now) else $error("power-on did not reset");
	property p_wdt_reset;
		$rose(wdt_expire) && wdt_enable && core_reset_n |-> ##[1:4] !core_reset_n;
	endproperty
	a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog did not reset");
	property p_ext_long;
		low_q == 8'h19 |-> !core_reset_n;
	endproperty
	a_ext_long: assert property (p_ext_long) else $error("long pin low ignored");
	property p_release_min;
		$rose(core_reset_n) |-> quiet_q >= 16'h001A;
	endproperty
	a_release_min: assert property (p_release_min) else $error("release too early");
	property p_wake;
		pd_wake && core_reset_n && !core_hold |-> ##2 (core_hold && core_reset_n) [*8];
	endproperty
	a_wake: assert property (p_wake) else $error("wake delay wrong");

	// ==========================================================
	// interrupt offer and bus answer
	property p_irq_cause;
		core_irq |-> $past(irq_src) != 8'h00;
	endproperty
	a_irq_cause: assert property (p_irq_cause) else $error("offer without request");
	property p_vec_range;
		core_irq |-> core_vector >= 9'h001 && core_vector <= 9'h008;
	endproperty
	a_vec_range: assert property (p_vec_range) else $error("vector out of range");
	property p_apb_answer;
		psel && !penable |=> pready;
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("no ready after setup");
	property p_unmapped;
		psel && !penable && paddr > 8'h10 |=> pslverr;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");

	c_release: cover property ($rose(core_reset_n));
	c_take: cover property (core_irq && core_irq_ack);
	c_err: cover property (pready && pslverr);
endmodule : rvsc_top_sva

bind rvsc_top rvsc_top_sva #(.OSC_LONG(OSC_LONG)) u_sva (.pclk, .presetn, .psel, .penable,
	.paddr, .pready, .pslverr, .por_active, .ext_reset_n, .wdt_expire, .wdt_enable,
	.bod_active, .pd_wake, .irq_src, .core_reset_n, .core_hold, .core_vector, .core_irq,
	.core_irq_ack);

// *** rvsc_core_model.sv ***
`timescale 1ns/1ps
// ==========================================================
// core stand-in: takes an offered vector after a set wait
module rvsc_core_model (
	input  wire logic       pclk,         // clock
	input  wire logic       presetn,      // async reset
	input  wire logic [3:0] ack_wait,     // cycles before taking
	input  wire logic       core_reset_n, // core reset
	input  wire logic       core_irq,     // offer
	input  wire logic [8:0] core_vector,  // offered vector
	output logic            core_irq_ack, // take pulse
	output logic [8:0]      taken_vec,    // last vector taken
	output logic [7:0]      taken_cnt     // vectors taken
);
	logic [3:0] wait_q; // cycles the offer has stood

	// only an offer seen while running is taken; the take pulse blocks the
	// next cycle and the offer is down after that, so any wait takes once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_q       <= 4'h0;
			core_irq_ack <= 1'b0;
			taken_vec    <= 9'h000;
			taken_cnt    <= 8'h00;
		end else if (core_irq && core_reset_n && !core_irq_ack && wait_q >= ack_wait) begin
			core_irq_ack <= 1'b1;
			taken_vec    <= core_vector;
			taken_cnt    <= taken_cnt + 8'h01;
			wait_q       <= 4'h0;
		end else begin
			core_irq_ack <= 1'b0;
			wait_q       <= core_irq ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule : rvsc_core_model

// *** reset_vector_startup_control_tb.sv ***
`timescale 1ns/1ps
// ==========================================================
// bench: start-up delays, vectors, sources and registers
module reset_vector_startup_control_tb;
	localparam int OSC_SIM = 16; // shortened long count
	typedef struct {logic [1:0] sel; logic fuse; int n;} rvsc_row_t;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, por_active;
	logic ext_reset_n, wdt_expire, wdt_enable, bod_active, osc_tick, pd_wake;
	logic brownout_enable_fuse, brownout_level_fuse, core_irq_ack, core_reset_n;
	logic core_hold, core_irq, irq, er;
	logic [1:0]  startup_delay_select;
	logic [3:0]  ack_wait;
	logic [7:0]  paddr, irq_src, taken_cnt;
	logic [8:0]  core_vector, taken_vec;
	logic [31:0] pwdata, prdata, rd;
	int          miscompares, n_checks, lo, hi;
	rvsc_row_t   rows [5];

	rvsc_top #(.OSC_LONG(OSC_SIM)) u_dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .por_active, .ext_reset_n, .wdt_expire,
		.wdt_enable, .bod_active, .osc_tick, .pd_wake, .startup_delay_select,
		.brownout_enable_fuse, .brownout_level_fuse, .irq_src, .core_irq_ack, .core_reset_n,
		.core_hold, .core_vector, .core_irq, .irq);
	rvsc_core_model u_core (.pclk, .presetn, .ack_wait, .core_reset_n, .core_irq,
		.core_vector, .core_irq_ack, .taken_vec, .taken_cnt);

	// clock, and an oscillator tick every other cycle
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) osc_tick <= ~osc_tick;

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer; an idle cycle after it keeps drives one per step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) miscompares++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb
	// cycles from source release to core release, against a window
	task automatic span();
		int c;
		c = 0;
		while (core_reset_n !== 1'b1 && c < 20000) begin
			@(posedge pclk);
			c++;
		end
		chk(32'(c >= lo && c <= hi), 32'h1);
	endtask : span
	task automatic summarize();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : summarize

	// hang guard, far beyond the expected run
	initial begin
		#750_000;
		miscompares++;
		summarize();
	end

	initial begin
		{presetn, ce, psel, penable, pwrite, paddr, pwdata, osc_tick, pd_wake} = '0;
		{ext_reset_n, wdt_expire, wdt_enable, bod_active, irq_src} = {1'b1, 11'h000};
		{startup_delay_select, brownout_enable_fuse, brownout_level_fuse} = 4'h2;
		{por_active, ce, ack_wait} = {2'b11, 4'h2};
		rows = '{'{2'h0, 1'b1, OSC_SIM}, '{2'h1, 1'b1, OSC_SIM}, '{2'h2, 1'b1, 4096},
			'{2'h3, 1'b1, 8}, '{2'h3, 1'b0, 32}};
		// ordinary cases: each select code, fuses captured after reset
		foreach (rows[i]) begin
			presetn              <= 1'b0;
			por_active           <= 1'b1;
			startup_delay_select <= rows[i].sel;
			brownout_enable_fuse <= rows[i].fuse;
			cyc(8);
			presetn <= 1'b1;
			cyc(2);
			apb(1'b0, rvsc_pkg::OFS_STATE, 32'h0);
			chk(32'(rd[4:2]), 32'({rows[i].fuse, rows[i].sel}));
			lo = 2 * rows[i].n + 17;
			hi = 2 * rows[i].n + 26;
			por_active <= 1'b0;
			span();
			chk(32'(core_vector), 32'h0);
		end
		// interrupt priority: lowest pending source wins, prompt and slow core
		apb(1'b1, rvsc_pkg::OFS_IRQ_EN, 32'hFF);
		for (int k = 0; k < 8; k++) begin
			irq_src  <= 8'hFF << k;
			ack_wait <= k[0] ? 4'h6 : 4'h2;
			apb(1'b1, rvsc_pkg::OFS_CTRL, 32'h1);
			cyc(12);
			chk(32'(taken_vec), 32'(k + 1));
			irq_src <= 8'h00;
			cyc(2);
		end
		chk(32'(taken_cnt), 32'h8);
		irq_src <= 8'h01;
		cyc(6);
		chk(32'(core_irq), 32'h0);
		apb(1'b1, rvsc_pkg::OFS_IRQ_EN, 32'hFFFFFF00);
		apb(1'b1, rvsc_pkg::OFS_CTRL, 32'h1);
		apb(1'b0, rvsc_pkg::OFS_IRQ_EN, 32'h0);
		chk(rd, 32'h0);
		chk(32'(core_irq), 32'h0);
		irq_src <= 8'h00;
		apb(1'b0, 8'h14, 32'h0);
		chk({rd[30:0], er}, 32'h1);
		// event status, mask and write-one-to-clear
		apb(1'b1, rvsc_pkg::OFS_EVT_MASK, 32'h1);
		cyc(2);
		chk(32'(irq), 32'h1);
		apb(1'b1, rvsc_pkg::OFS_EVT_STAT, 32'h1F);
		apb(1'b0, rvsc_pkg::OFS_EVT_STAT, 32'h0);
		chk({rd[30:0], irq}, 32'h0);
		// pin: short pulse ignored, long pulse resets and re-delays
		lo = 81;
		hi = 94;
		ext_reset_n <= 1'b0;
		cyc(15);
		ext_reset_n <= 1'b1;
		cyc(4);
		chk(32'(core_reset_n), 32'h1);
		ext_reset_n <= 1'b0;
		cyc(30);
		chk(32'({core_reset_n, core_vector}), 32'h0);
		ext_reset_n <= 1'b1;
		span();
		apb(1'b0, rvsc_pkg::OFS_EVT_STAT, 32'h0);
		chk(32'(rd[rvsc_pkg::EVT_EXT_BIT]), 32'h1);
		// watchdog: ignored while disabled, resets when enabled
		wdt_expire <= 1'b1;
		cyc(6);
		chk(32'(core_reset_n), 32'h1);
		wdt_expire <= 1'b0;
		cyc(1);
		{wdt_enable, wdt_expire} <= 2'b11;
		cyc(1);
		wdt_expire <= 1'b0;
		// the pulse needs two edges to reach core_reset_n; start timing after it
		cyc(2);
		span();
		// power-on again in mid-delay restarts the count
		por_active <= 1'b1;
		cyc(3);
		por_active <= 1'b0;
		cyc(30);
		por_active <= 1'b1;
		cyc(2);
		por_active <= 1'b0;
		span();
		// wake from power-down: clock part only, core not reset
		pd_wake <= 1'b1;
		cyc(1);
		pd_wake <= 1'b0;
		cyc(4);
		chk(32'({core_reset_n, core_hold}), 32'h3);
		// clock enable low freezes the wake count part way
		ce <= 1'b0;
		cyc(20);
		ce <= 1'b1;
		chk(32'(core_hold), 32'h1);
		cyc(22);
		chk(32'(core_hold), 32'h0);
		// brown-out with its fuse programmed
		bod_active <= 1'b1;
		cyc(4);
		chk(32'(core_reset_n), 32'h0);
		bod_active <= 1'b0;
		span();
		summarize();
	end
endmodule : reset_vector_startup_control_tb
